// ==== rtl/bsu_pkg.sv ====
package bsu_pkg;

  // register word addresses, low 28 bits of the peripheral page
  localparam logic [27:0] OFS_BUS_CONTROL_ONE    = 28'hFFFFFE0;
  localparam logic [27:0] OFS_BUS_CONTROL_TWO    = 28'hFFFFFE4;
  localparam logic [27:0] OFS_WAIT_STATE_CONTROL = 28'hFFFFFE8;
  localparam logic [27:0] OFS_MEMORY_KIND_CTRL   = 28'hFFFFFEC;
  localparam logic [27:0] OFS_REFRESH_TIMER_CS   = 28'hFFFFFF0;
  localparam logic [27:0] OFS_REFRESH_TIMER_CNT  = 28'hFFFFFF4;
  localparam logic [27:0] OFS_REFRESH_INTERVAL   = 28'hFFFFFF8;
  localparam logic [27:0] OFS_HALF_ADD           = 28'h0000002;
  localparam int          NUM_REGS               = 7;

  localparam logic [15:0] RST_BUS_CONTROL_ONE    = 16'h03F0;
  localparam logic [15:0] RST_BUS_CONTROL_TWO    = 16'h00FC;
  localparam logic [15:0] RST_WAIT_STATE_CONTROL = 16'hAAFF;
  localparam logic [15:0] RST_ZERO               = 16'h0000;
  localparam logic [15:0] WRITE_KEY              = 16'hA55A;

  // bus_control_one fields
  localparam int          BC1_MASTER_BIT         = 15;
  localparam int          BC1_BURST_ROM_BIT      = 11;
  localparam int          BC1_PART_SHARE_BIT     = 10;
  localparam logic [15:0] BC1_RSVD_MASK          = 16'h6008;

  // address map
  localparam logic [31:0] CS_REGION_TOP          = 32'h07FFFFFF;
  localparam logic [31:0] THRU_BASE              = 32'h20000000;
  localparam logic [31:0] THRU_TOP               = 32'h27FFFFFF;
  localparam logic [31:0] PURGE_BASE             = 32'h40000000;
  localparam logic [31:0] PURGE_TOP              = 32'h47FFFFFF;
  localparam logic [31:0] ADDR_ARRAY_BASE        = 32'h60000000;
  localparam logic [31:0] ADDR_ARRAY_TOP         = 32'h7FFFFFFF;
  localparam logic [31:0] DATA_ARRAY_BASE        = 32'hC0000000;
  localparam logic [31:0] DATA_ARRAY_TOP         = 32'hC0000FFF;
  localparam logic [31:0] SDRAM_MODE_BASE        = 32'hFFFF8000;
  localparam logic [31:0] SDRAM_MODE_TOP         = 32'hFFFFBFFF;
  localparam logic [31:0] PERIPH_BASE            = 32'hFFFFFE00;
  localparam int          EXT_ADDR_W             = 27;
  localparam int          CS_SEL_LSB             = 25;

  typedef enum logic [2:0] {
    SPC_EXTERNAL = 3'h0,
    SPC_CACHE    = 3'h1,
    SPC_SDRAM_MD = 3'h2,
    SPC_PERIPH   = 3'h3,
    SPC_RESERVED = 3'h4
  } bsu_space_t;

  typedef enum logic [2:0] {
    MK_ORDINARY  = 3'h0,
    MK_BURST_ROM = 3'h1,
    MK_SDRAM     = 3'h2,
    MK_DRAM      = 3'h3,
    MK_PSEUDO    = 3'h4
  } bsu_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h1,
    ST_ARB      = 4'h2,
    ST_ACCESS   = 4'h4,
    ST_RELEASED = 4'h8
  } bsu_state_t;

endpackage

// ==== rtl/bsu_addr_dec.sv ====
`timescale 1ns/1ps
module bsu_addr_dec (
  input  wire logic [31:0]        i_addr,     // processor address
  output bsu_pkg::bsu_space_t     o_space,    // class of the space hit
  output logic      [1:0]         o_cs_idx,   // chip-select space number
  output logic      [26:0]        o_ext_addr  // address on the external bus
);

  always_comb begin
    o_cs_idx   = i_addr[bsu_pkg::CS_SEL_LSB +: 2];
    o_ext_addr = i_addr[bsu_pkg::EXT_ADDR_W-1:0];
    if (i_addr <= bsu_pkg::CS_REGION_TOP) begin
      o_space = bsu_pkg::SPC_EXTERNAL;
    end else if (i_addr >= bsu_pkg::THRU_BASE && i_addr <= bsu_pkg::THRU_TOP) begin
      o_space = bsu_pkg::SPC_EXTERNAL;
    end else if ((i_addr >= bsu_pkg::PURGE_BASE && i_addr <= bsu_pkg::PURGE_TOP) ||
                 (i_addr >= bsu_pkg::ADDR_ARRAY_BASE && i_addr <= bsu_pkg::ADDR_ARRAY_TOP) ||
                 (i_addr >= bsu_pkg::DATA_ARRAY_BASE && i_addr <= bsu_pkg::DATA_ARRAY_TOP)) begin
      o_space = bsu_pkg::SPC_CACHE;
    end else if (i_addr >= bsu_pkg::SDRAM_MODE_BASE && i_addr <= bsu_pkg::SDRAM_MODE_TOP) begin
      o_space = bsu_pkg::SPC_SDRAM_MD;
    end else if (i_addr >= bsu_pkg::PERIPH_BASE) begin
      o_space = bsu_pkg::SPC_PERIPH;
    end else begin
      o_space = bsu_pkg::SPC_RESERVED;
    end
  end

endmodule

// ==== rtl/bsu_reg_bank.sv ====
`timescale 1ns/1ps
module bsu_reg_bank #(
  parameter int N_REGS = bsu_pkg::NUM_REGS
) (
  input  wire logic        i_ref_clk, // system clock
  input  wire logic        i_rst,     // async reset, active high
  input  wire logic        i_we,      // write strobe
  input  wire logic [2:0]  i_idx,     // register index
  input  wire logic [15:0] i_wdata,   // write data
  input  wire logic        i_re,      // read strobe
  input  wire logic        i_master,  // strap value for the mode bit
  output logic      [15:0] o_rdata,   // registered read data
  output logic      [15:0] o_bc1      // live bus_control_one
);

  initial begin
    if (N_REGS != bsu_pkg::NUM_REGS) $error("bsu_reg_bank: N_REGS must be 7");
  end

  logic [15:0] regs_q [N_REGS];

  function automatic logic [15:0] reset_of(input int k);
    case (k)
      0:       reset_of = bsu_pkg::RST_BUS_CONTROL_ONE;
      1:       reset_of = bsu_pkg::RST_BUS_CONTROL_TWO;
      2:       reset_of = bsu_pkg::RST_WAIT_STATE_CONTROL;
      default: reset_of = bsu_pkg::RST_ZERO;
    endcase
  endfunction

  for (genvar g = 0; g < N_REGS; g++) begin : g_reg
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        regs_q[g] <= reset_of(g);
      end else if (i_we && i_idx == 3'(g)) begin
        regs_q[g] <= i_wdata;
      end
    end
  end

  // reserved bits forced to zero, mode bit mirrors the strap
  always_comb begin
    o_bc1 = regs_q[0] & ~bsu_pkg::BC1_RSVD_MASK;
    o_bc1[bsu_pkg::BC1_MASTER_BIT] = i_master;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_re) begin
      o_rdata <= (i_idx == 3'h0) ? o_bc1 : regs_q[i_idx];
    end
  end

endmodule

// ==== rtl/bsu_top.sv ====
`timescale 1ns/1ps
// Operation
// - register is 16 bits; 32-bit read returns zeros in the upper half
// - 32-bit write takes effect only when upper half equals the key
// - half-word accesses only read; writes need the keyed long form
// - registers sit at their word address, half-word at address plus two
// - external range split into four 32-Mbyte chip-select spaces from zero
// - cache-through region aliases the cached region; 128 Mbytes external
// - allowed memory kinds fixed per chip-select space
// - purge, address array and data array spaces go to cache control
// - two lower lane strobes serve D15-D8 and D7-D0 per memory kind
// - read strobe low during reads; external buffer drives only then
// - arbitration input: grant in share/slave, release request in total master
// - arbitration output: request in share/slave, grant in total master
// - clock-enable output for synchronous DRAM, low for self-refresh
// - top two address bits pick the space, 25 bits address within it
// - partial-share master: only space two needs bus ownership
module bsu_top (
  input  wire logic        i_ref_clk,          // 20 MHz system clock
  input  wire logic        i_rst,              // async reset, active high
  input  wire logic        i_slave_strap,      // mode strap, 1 = slave
  input  wire logic        i_acc_req,          // access request pulse
  input  wire logic [31:0] i_acc_addr,         // access address
  input  wire logic        i_acc_wr,           // 1 = write
  input  wire logic        i_acc_long,         // 1 = 32-bit, 0 = 16-bit
  input  wire logic [1:0]  i_acc_lane,         // lanes D15-D8, D7-D0 used
  input  wire logic [31:0] i_acc_wdata,        // write data
  input  wire logic        i_acc_vec,          // access is a vector fetch
  input  wire logic        i_self_refresh_req, // hold sdram in self-refresh
  input  wire logic        i_wait_n,           // hardware wait, low = wait
  input  wire logic        i_arb_in_n,         // grant or release request
  input  wire logic [31:0] i_ext_rdata,        // external read data
  output logic             o_acc_done,         // access finished pulse
  output logic      [31:0] o_acc_rdata,        // access read data
  output logic             o_acc_err,          // reserved space hit
  output logic             o_cache_req,        // cache-control space pulse
  output logic      [3:0]  o_cs_n,             // chip selects, low active
  output logic      [26:0] o_ext_addr,         // external address
  output logic      [31:0] o_ext_wdata,        // external write data
  output logic             o_data_oe_n,        // low while driving data
  output logic             o_bus_oe_n,         // low while driving strobes
  output logic      [2:0]  o_mem_kind,         // kind of the current access
  output logic             o_lane_strobe_third_byte_n, // lane D15-D8
  output logic             o_lane_strobe_low_byte_n,   // lane D7-D0
  output logic             o_read_strobe_n,    // read strobe, low active
  output logic             o_vector_fetch_flag_out,    // vector fetch
  output logic             o_arb_out_n,        // request or grant out
  output logic             o_sdram_cke         // sdram clock enable
);

  ////////////////////////////////////////////////////////////////////////////
  // decode and register bank

  bsu_pkg::bsu_space_t space;
  logic [1:0]          cs_idx;
  logic [26:0]         ext_addr;
  logic [15:0]         bc1;
  logic [15:0]         reg_rdata;
  logic                slave_q;
  logic                strap_done_q;

  bsu_addr_dec u_dec (
    .i_addr     (i_acc_addr),
    .o_space    (space),
    .o_cs_idx   (cs_idx),
    .o_ext_addr (ext_addr)
  );

  logic       reg_hit;
  logic       reg_half;
  logic [2:0] reg_idx;
  logic       reg_we;
  logic       reg_re;

  // long accesses hit the word address, half-words the address plus two
  always_comb begin
    reg_hit  = 1'b0;
    reg_half = 1'b0;
    reg_idx  = 3'h0;
    for (int k = 0; k < bsu_pkg::NUM_REGS; k++) begin
      if (i_acc_addr[31:28] == 4'hF &&
          i_acc_addr[27:0] == bsu_pkg::OFS_BUS_CONTROL_ONE + 28'(4 * k) +
            (i_acc_long ? 28'h0000000 : bsu_pkg::OFS_HALF_ADD)) begin
        reg_hit  = 1'b1;
        reg_half = ~i_acc_long;
        reg_idx  = 3'(k);
      end
    end
  end

  bsu_pkg::bsu_state_t state_q;
  logic                idle;
  assign idle   = (state_q == bsu_pkg::ST_IDLE);
  assign reg_re = idle && i_acc_req && reg_hit;
  assign reg_we = reg_re && i_acc_wr && !reg_half &&
                  i_acc_wdata[31:16] == bsu_pkg::WRITE_KEY;

  bsu_reg_bank u_regs (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_we      (reg_we),
    .i_idx     (reg_idx),
    .i_wdata   (i_acc_wdata[15:0]),
    .i_re      (reg_re),
    .i_master  (slave_q),
    .o_rdata   (reg_rdata),
    .o_bc1     (bc1)
  );

  // strap caught on the first edge after reset release
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      slave_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      slave_q      <= i_slave_strap;
      strap_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory kind per space, from the live control bits

  bsu_pkg::bsu_kind_t kind;
  logic [2:0]         dram_sel;
  assign dram_sel = bc1[2:0];

  always_comb begin
    case (cs_idx)
      2'h0:    kind = bc1[bsu_pkg::BC1_BURST_ROM_BIT] ? bsu_pkg::MK_BURST_ROM
                                                      : bsu_pkg::MK_ORDINARY;
      2'h1:    kind = bsu_pkg::MK_ORDINARY;
      2'h2:    kind = dram_sel[2] ? bsu_pkg::MK_SDRAM : bsu_pkg::MK_ORDINARY;
      default: begin
        case (dram_sel)
          3'h1, 3'h5: kind = bsu_pkg::MK_SDRAM;
          3'h2:       kind = bsu_pkg::MK_DRAM;
          3'h3:       kind = bsu_pkg::MK_PSEUDO;
          default:    kind = bsu_pkg::MK_ORDINARY;
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // ownership policy

  logic total_master;
  logic need_arb;
  assign total_master = !slave_q && !bc1[bsu_pkg::BC1_PART_SHARE_BIT];
  // in partial share only space two is shared
  assign need_arb = slave_q || (bc1[bsu_pkg::BC1_PART_SHARE_BIT] && cs_idx == 2'h2);

  ////////////////////////////////////////////////////////////////////////////
  // bus state machine

  bsu_pkg::bsu_state_t state_d;
  logic                ext_go;
  logic                acc_end;
  logic                cur_wr_q;
  logic                cur_arb_q;

  assign ext_go  = idle && i_acc_req && space == bsu_pkg::SPC_EXTERNAL;
  // wait input only matters while we own the bus
  assign acc_end = (state_q == bsu_pkg::ST_ACCESS) && i_wait_n;

  always_comb begin
    state_d = state_q;
    case (state_q)
      bsu_pkg::ST_IDLE: begin
        if (total_master && !i_arb_in_n) begin
          state_d = bsu_pkg::ST_RELEASED;
        end else if (ext_go) begin
          // fields are captured on entry, so pins use them one cycle later
          state_d = bsu_pkg::ST_ARB;
        end
      end
      bsu_pkg::ST_ARB: begin
        if (!cur_arb_q || !i_arb_in_n) begin
          state_d = bsu_pkg::ST_ACCESS;
        end
      end
      bsu_pkg::ST_ACCESS: begin
        if (i_wait_n) begin
          state_d = bsu_pkg::ST_IDLE;
        end
      end
      bsu_pkg::ST_RELEASED: begin
        if (i_arb_in_n) begin
          state_d = bsu_pkg::ST_IDLE;
        end
      end
      default: state_d = bsu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= bsu_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // captured external access

  logic       cur_vec_q;
  logic [1:0] cur_lane_q;
  logic [1:0] cur_cs_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_wr_q    <= 1'b0;
      cur_arb_q   <= 1'b0;
      cur_vec_q   <= 1'b0;
      cur_lane_q  <= 2'h0;
      cur_cs_q    <= 2'h0;
      o_ext_addr  <= 27'h0000000;
      o_ext_wdata <= 32'h00000000;
      o_mem_kind  <= 3'h0;
    end else if (ext_go && state_d != bsu_pkg::ST_RELEASED) begin
      cur_wr_q    <= i_acc_wr;
      cur_arb_q   <= need_arb;
      cur_vec_q   <= i_acc_vec;
      cur_lane_q  <= i_acc_lane;
      cur_cs_q    <= cs_idx;
      o_ext_addr  <= ext_addr;
      o_ext_wdata <= i_acc_wdata;
      o_mem_kind  <= kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  logic       access_d;
  logic       basic_d;
  logic [1:0] lane_act_d;
  assign access_d = (state_d == bsu_pkg::ST_ACCESS);
  assign basic_d  = (o_mem_kind == bsu_pkg::MK_ORDINARY ||
                     o_mem_kind == bsu_pkg::MK_BURST_ROM);
  // basic interface marks written lanes only; others strobe every used lane
  assign lane_act_d = (access_d && (!basic_d || cur_wr_q)) ? cur_lane_q : 2'h0;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cs_n                     <= 4'hF;
      o_lane_strobe_third_byte_n <= 1'b1;
      o_lane_strobe_low_byte_n   <= 1'b1;
      o_read_strobe_n            <= 1'b1;
      o_vector_fetch_flag_out    <= 1'b0;
      o_data_oe_n                <= 1'b1;
      o_bus_oe_n                 <= 1'b0;
    end else begin
      o_cs_n                     <= access_d ? ~(4'h1 << cur_cs_q) : 4'hF;
      o_lane_strobe_third_byte_n <= ~lane_act_d[1];
      o_lane_strobe_low_byte_n   <= ~lane_act_d[0];
      o_read_strobe_n            <= ~(access_d && !cur_wr_q);
      o_vector_fetch_flag_out    <= access_d && cur_vec_q;
      o_data_oe_n                <= ~(access_d && cur_wr_q);
      o_bus_oe_n                 <= (state_d == bsu_pkg::ST_RELEASED);
    end
  end

  // request held through arbitration and the access; grant while released
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arb_out_n <= 1'b1;
    end else if (total_master) begin
      o_arb_out_n <= ~(state_d == bsu_pkg::ST_RELEASED);
    end else begin
      o_arb_out_n <= ~((state_d == bsu_pkg::ST_ARB && !idle) ||
                       (state_d == bsu_pkg::ST_ACCESS && cur_arb_q) ||
                       (state_q == bsu_pkg::ST_IDLE && ext_go && need_arb));
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sdram_cke <= 1'b1;
    end else begin
      o_sdram_cke <= ~i_self_refresh_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access answers; non-external spaces finish one cycle later, register accesses two cycles later

  logic local_go;
  logic reg_rd_q;
  assign local_go = idle && i_acc_req && space != bsu_pkg::SPC_EXTERNAL &&
                    !(total_master && !i_arb_in_n);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_acc_done  <= 1'b0;
      o_acc_err   <= 1'b0;
      o_cache_req <= 1'b0;
      reg_rd_q    <= 1'b0;
      o_acc_rdata <= 32'h00000000;
    end else begin
      // register answers wait a cycle for the bank's registered read data
      o_acc_done  <= (local_go && !reg_re) || acc_end || reg_rd_q;
      o_acc_err   <= local_go && space == bsu_pkg::SPC_RESERVED;
      o_cache_req <= local_go && space == bsu_pkg::SPC_CACHE;
      reg_rd_q    <= reg_re;
      if (acc_end && !cur_wr_q) begin
        o_acc_rdata <= i_ext_rdata;
      end else if (reg_rd_q) begin
        o_acc_rdata <= {16'h0000, reg_rdata};
      end else if (local_go) begin
        o_acc_rdata <= 32'h00000000;
      end
    end
  end

endmodule

// ==== dv/bsu_checker.sv ====
`timescale 1ns/1ps
module bsu_checker (
  input wire logic        i_ref_clk,          // clock
  input wire logic        i_rst,              // reset
  input wire logic        i_acc_req,          // request
  input wire logic [31:0] i_acc_addr,         // address
  input wire logic        i_acc_wr,           // write
  input wire logic        i_self_refresh_req, // self-refresh
  input wire logic        o_acc_done,         // done
  input wire logic [31:0] o_acc_rdata,        // read data
  input wire logic        o_acc_err,          // error
  input wire logic        o_cache_req,        // cache space
  input wire logic [3:0]  o_cs_n,             // chip selects
  input wire logic [26:0] o_ext_addr,         // ext address
  input wire logic        o_read_strobe_n,    // read strobe
  input wire logic        o_data_oe_n,        // data enable
  input wire logic        o_bus_oe_n,         // bus enable
  input wire logic        o_sdram_cke         // clock enable
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic        reg_q;
  logic        wr_q;
  logic [31:0] addr_q;
  wire         is_reg = i_acc_addr[31:5] == 27'h7FFFFFF && i_acc_addr[4:0] < 5'h1C;
  wire         is_cc = i_acc_addr[31:27] == 5'h08 || i_acc_addr[31:29] == 3'h3;
  ////////////////////////////////////////////////////////////////////////////
  // one request outstanding, so the last one names the access in flight
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      reg_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 32'h00000000;
    end else if (i_acc_req) begin
      reg_q <= is_reg;
      wr_q <= i_acc_wr;
      addr_q <= i_acc_addr;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_cs_onehot: assert property (o_cs_n != 4'hF |-> o_cs_n == ~(4'h1 << o_ext_addr[26:25]))
    else $error("chip select does not match address");
  a_ext_alias: assert property (o_cs_n != 4'hF |-> o_ext_addr == addr_q[26:0])
    else $error("external address differs from request");
  a_upper_zero: assert property (o_acc_done && reg_q |-> o_acc_rdata[31:16] == 16'h0000)
    else $error("register read upper half not zero");
  a_reg_answer: assert property (i_acc_req && is_reg |=> ##1 o_acc_done && !o_acc_err && o_cs_n == 4'hF)
    else $error("register access not answered locally");
  a_cache_route: assert property (i_acc_req && is_cc |=> o_acc_done && o_cache_req)
    else $error("cache space not routed to cache control");
  a_read_strobe: assert property (!o_read_strobe_n |-> o_cs_n != 4'hF && !wr_q && o_data_oe_n)
    else $error("read strobe outside an external read");
  a_cke_low: assert property (i_self_refresh_req |=> !o_sdram_cke)
    else $error("clock enable not low for self-refresh");
  a_release_float: assert property (o_bus_oe_n |-> o_cs_n == 4'hF && o_read_strobe_n)
    else $error("access active while bus released");
  c_ext_read: cover property (!o_read_strobe_n ##1 o_acc_done);
  c_release: cover property ($rose(o_bus_oe_n));
  c_error: cover property (o_acc_err);
endmodule

// ==== dv/bsu_ext_mem_model.sv ====
`timescale 1ns/1ps
module bsu_ext_mem_model (
  input  wire logic        i_ref_clk,       // clock
  input  wire logic [3:0]  i_cs_n,          // chip selects
  input  wire logic        i_read_strobe_n, // read strobe
  input  wire logic [26:0] i_ext_addr,      // address
  input  wire logic        i_arb_out_n,     // device request
  input  wire logic        i_share,         // partial-share mode
  input  wire logic        i_release,       // ask for the bus
  input  wire logic        i_slow,          // insert waits
  output logic      [31:0] o_rdata,         // read data
  output logic             o_wait_n,        // wait, low active
  output logic             o_arb_in_n       // grant or release
);
  logic [1:0]  cnt_q = 2'h0;
  logic        grant_q = 1'b0;
  logic [31:0] last_q = 32'h00000000;
  wire         sel = i_cs_n != 4'hF;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk) begin
    cnt_q <= sel ? cnt_q + {1'b0, cnt_q != 2'h3} : 2'h0;
    grant_q <= !i_arb_out_n;
    last_q <= o_rdata;
  end
  // data only while the read strobe is low, otherwise a toggling pattern
  assign o_rdata = (sel && !i_read_strobe_n) ? {i_ext_addr[15:0], ~i_ext_addr[15:0]}
                                             : ~last_q;
  assign o_wait_n = !(i_slow && sel && cnt_q < 2'h2);
  assign o_arb_in_n = !(i_share ? grant_q : i_release);
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cs;
    logic        cc;
    logic        err;
    logic        arb;
  } bsu_row_t;
  logic i_ref_clk, i_rst, i_slave_strap, i_acc_req, i_acc_wr, i_acc_long, i_acc_vec;
  logic i_self_refresh_req, i_wait_n, i_arb_in_n, o_acc_done, o_acc_err, o_cache_req;
  logic o_data_oe_n, o_bus_oe_n, o_lane_strobe_third_byte_n, o_lane_strobe_low_byte_n;
  logic o_read_strobe_n, o_vector_fetch_flag_out, o_arb_out_n, o_sdram_cke;
  logic share, rel, slow, e_err, e_cc, rs_seen, arb_seen;
  logic [1:0]  i_acc_lane, ln_seen;
  logic [2:0]  o_mem_kind;
  logic [3:0]  o_cs_n, cs_seen;
  logic [26:0] o_ext_addr, ea;
  logic [31:0] i_acc_addr, i_acc_wdata, i_ext_rdata, o_acc_rdata, o_ext_wdata, rd;
  int          n_fail, comparisons, k, p;
  logic [15:0] rst_v [7] = '{bsu_pkg::RST_BUS_CONTROL_ONE, bsu_pkg::RST_BUS_CONTROL_TWO,
    bsu_pkg::RST_WAIT_STATE_CONTROL, bsu_pkg::RST_ZERO, bsu_pkg::RST_ZERO,
    bsu_pkg::RST_ZERO, bsu_pkg::RST_ZERO};
  bsu_row_t    rows [10] = '{'{32'h00000010, 4'hE, 0, 0, 0}, '{32'h02000010, 4'hD, 0, 0, 0},
    '{32'h04000010, 4'hB, 0, 0, 1}, '{32'h06000010, 4'h7, 0, 0, 0},
    '{32'h20000010, 4'hE, 0, 0, 0}, '{32'h27FFFFFC, 4'h7, 0, 0, 0},
    '{32'h40000000, 4'hF, 1, 0, 0}, '{32'h60000000, 4'hF, 1, 0, 0},
    '{32'hC0000FFC, 4'hF, 1, 0, 0}, '{32'h08000000, 4'hF, 0, 1, 0}};
  ////////////////////////////////////////////////////////////////////////////
  bsu_top bsu_top_inst (.i_ref_clk, .i_rst, .i_slave_strap, .i_acc_req, .i_acc_addr,
    .i_acc_wr, .i_acc_long, .i_acc_lane, .i_acc_wdata, .i_acc_vec, .i_self_refresh_req,
    .i_wait_n, .i_arb_in_n, .i_ext_rdata, .o_acc_done, .o_acc_rdata, .o_acc_err,
    .o_cache_req, .o_cs_n, .o_ext_addr, .o_ext_wdata, .o_data_oe_n, .o_bus_oe_n,
    .o_mem_kind, .o_lane_strobe_third_byte_n, .o_lane_strobe_low_byte_n, .o_read_strobe_n,
    .o_vector_fetch_flag_out, .o_arb_out_n, .o_sdram_cke);
  bsu_ext_mem_model bsu_ext_mem_model_inst (.i_ref_clk, .i_cs_n(o_cs_n),
    .i_read_strobe_n(o_read_strobe_n), .i_ext_addr(o_ext_addr), .i_arb_out_n(o_arb_out_n),
    .i_share(share), .i_release(rel), .i_slow(slow), .o_rdata(i_ext_rdata),
    .o_wait_n(i_wait_n), .o_arb_in_n(i_arb_in_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one request pulse; qualifiers stay put until the next request
  task automatic acc(input logic [31:0] a, input logic w, input logic l,
                     input logic [31:0] d, input logic [1:0] ln);
    int i;
    @(posedge i_ref_clk);
    i_acc_req <= 1'b1;
    i_acc_addr <= a;
    i_acc_wr <= w;
    i_acc_long <= l;
    i_acc_wdata <= d;
    i_acc_lane <= ln;
    @(posedge i_ref_clk);
    i_acc_req <= 1'b0;
    {cs_seen, ea, rs_seen, ln_seen, arb_seen} = {4'hF, 27'h0, 1'b1, 2'h3, 1'b1};
    for (i = 0; i < 60; i++) begin
      #1;
      if (o_cs_n != 4'hF) ea = o_ext_addr;
      cs_seen &= o_cs_n;
      rs_seen &= o_read_strobe_n;
      ln_seen &= {o_lane_strobe_third_byte_n, o_lane_strobe_low_byte_n};
      arb_seen &= o_arb_out_n;
      if (o_acc_done === 1'b1) break;
      @(posedge i_ref_clk);
    end
    {rd, e_err, e_cc} = {o_acc_rdata, o_acc_err, o_cache_req};
    if (i == 60) begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic wait_bus(input logic v);
    int i;
    for (i = 0; i < 20 && o_bus_oe_n !== v; i++) @(posedge i_ref_clk);
    #1;
    if (o_bus_oe_n !== v) begin
      n_fail++;
      finish_test();
    end
    chk({31'h0, o_arb_out_n}, {31'h0, !v});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    {i_rst, i_slave_strap, i_acc_req, i_acc_wr, i_acc_long, i_acc_vec} = 6'h20;
    {i_self_refresh_req, share, rel, slow, i_acc_lane} = 6'h00;
    {i_acc_addr, i_acc_wdata, n_fail, comparisons} = '0;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    for (k = 0; k < 7; k++) begin
      acc(32'hFFFFFFE0 + 32'(4 * k), 0, 1, 0, 0);
      chk(rd, {16'h0000, rst_v[k]});
      acc(32'hFFFFFFE2 + 32'(4 * k), 0, 0, 0, 0);
      chk({16'h0000, rd[15:0]}, {16'h0000, rst_v[k]});
    end
    rel <= 1'b1;
    wait_bus(1'b1);
    rel <= 1'b0;
    wait_bus(1'b0);
    // memory setup before any space other than zero
    acc(32'hFFFFFFE8, 1, 1, 32'hA55A1234, 2'h3);
    acc(32'hFFFFFFE8, 1, 1, 32'h5AA51111, 2'h3);
    acc(32'hFFFFFFEA, 1, 0, 32'h00002222, 2'h1);
    acc(32'hFFFFFFE8, 0, 1, 0, 0);
    chk(rd, 32'h00001234);
    acc(32'hFFFFFFE0, 1, 1, 32'hA55A07F0, 2'h3);
    acc(32'hFFFFFFE0, 0, 1, 0, 0);
    chk(rd, 32'h000007F0);
    share <= 1'b1;
    for (p = 0; p < 2; p++) begin
      slow <= p[0];
      foreach (rows[r]) begin
        acc(rows[r].addr, 0, 1, 0, 2'h3);
        chk(cs_seen, rows[r].cs);
        chk(e_cc, rows[r].cc);
        chk(e_err, rows[r].err);
        chk(arb_seen, {31'h0, !rows[r].arb});
        if (rows[r].cs != 4'hF) begin
          chk(ea, rows[r].addr[26:0]);
          chk(rd, {rows[r].addr[15:0], ~rows[r].addr[15:0]});
          chk(rs_seen, 0);
        end
      end
    end
    for (k = 1; k < 4; k++) begin
      acc(32'h02000020, 1, 0, 32'h0000BEEF, k[1:0]);
      chk(ln_seen, {30'h0, ~k[1:0]});
      chk(o_ext_wdata, 32'h0000BEEF);
      chk(rs_seen, 1);
    end
    i_self_refresh_req <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_sdram_cke, 0);
    @(posedge i_ref_clk);
    i_self_refresh_req <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_sdram_cke, 1);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    acc(32'hFFFFFFE0, 0, 1, 0, 0);
    chk(rd, {16'h0000, bsu_pkg::RST_BUS_CONTROL_ONE});
    finish_test();
  end
endmodule
bind bsu_top bsu_checker bsu_checker_inst (.i_ref_clk, .i_rst, .i_acc_req, .i_acc_addr,
  .i_acc_wr, .i_self_refresh_req, .o_acc_done, .o_acc_rdata, .o_acc_err, .o_cache_req,
  .o_cs_n, .o_ext_addr, .o_read_strobe_n, .o_data_oe_n, .o_bus_oe_n, .o_sdram_cke);
